// ### rtl/ppc_port.sv
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "ppc_map.svh"
module ppc_port #(
  parameter int PINS = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // pins
  input wire logic [15:0] pin_i,
  output logic [15:0] pin_o,
  output logic [15:0] pin_oe_o,
  output logic [15:0] drive_strength_o,
  // pin multiplexer
  output logic [31:0] pin_function_o
);
  initial
  begin
    if (PINS != 16) $error("only sixteen pins supported");
  end
  ppc_pkg::ppc_req_type req;
  ppc_pkg::ppc_pad_type pad;
  logic [31:0] pin_function_select;
  logic [15:0] drive_strength_select;
  logic [15:0] input_path_enable;
  logic [15:0] output_drive_enable;
  logic [15:0] out_data;
  logic [15:0] in_value;
  // a transfer completes where waitrequest stands low
  wire ack = !avs_waitrequest_o;
  wire [15:0] next_out;
  wire [15:0] next_pad;
  assign req.read = avs_read_i;
  assign req.write = avs_write_i;
  assign req.address = avs_address_i;
  assign req.writedata = avs_writedata_i;
  // byte-lane mask
  wire [31:0] lane_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wdata = req.writedata & lane_mask;
  // writes land on the completing edge, reads are captured one edge before it
  wire do_write = req.write && ack;
  wire do_read = req.read && !ack;
  wire sel_func = req.address == 5'(`PPC_OFF_FUNC);
  wire sel_clr = req.address == 5'(`PPC_OFF_CLR);
  wire sel_drive = req.address == 5'(`PPC_OFF_DRIVE);
  wire sel_inen = req.address == 5'(`PPC_OFF_INEN);
  wire sel_outen = req.address == `PPC_OFF_OUTEN;
  wire sel_out = req.address == `PPC_OFF_OUT;
  wire sel_in = req.address == `PPC_OFF_IN;
  // write strobes per register
  wire wr_func = do_write && sel_func;
  wire wr_drive = do_write && sel_drive;
  wire wr_inen = do_write && sel_inen;
  wire wr_outen = do_write && sel_outen;
  wire wr_out = do_write && sel_out;
  wire wr_clr = do_write && sel_clr;
  // write masks per register
  wire [31:0] next_function = (pin_function_select & ~lane_mask) | wdata;
  wire [15:0] next_drive = (drive_strength_select & ~lane_mask[15:0]) | wdata[15:0];
  wire [15:0] next_inen = (input_path_enable & ~lane_mask[15:0]) | wdata[15:0];
  wire [15:0] next_outen = (output_drive_enable & ~lane_mask[15:0]) | wdata[15:0];
  wire [15:0] clear_mask = wr_clr ? wdata[15:0] : `PPC_ZERO_HALF;
  // per-pin output data and gated pad drive
  for (genvar n = 0; n < PINS; n++)
  begin : g_pin
    assign next_out[n] = wr_out
      ? (lane_mask[n] ? wdata[n] : out_data[n])
      : (out_data[n] & !clear_mask[n]);
    assign next_pad[n] = pad.out[n] & pad.oe[n];
  end
  // read mux; clear register reads zero
  wire [31:0] next_readdata =
    sel_func ? pin_function_select :
    sel_drive ? {`PPC_ZERO_HALF, drive_strength_select} :
    sel_inen ? {`PPC_ZERO_HALF, input_path_enable} :
    sel_outen ? {`PPC_ZERO_HALF, output_drive_enable} :
    sel_out ? {`PPC_ZERO_HALF, out_data} :
    sel_in ? {`PPC_ZERO_HALF, in_value} :
    `PPC_UNMAPPED_DATA;
  ppc_pin_sync #(
    .WIDTH(16)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_i),
    .enable_i(input_path_enable),
    .value_o(in_value)
  );
  // waitrequest drops for one cycle after a request is first seen
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      avs_waitrequest_o <= `PPC_RST_WAIT;
    end
    else
    begin
      avs_waitrequest_o <= !((req.read || req.write) && avs_waitrequest_o);
    end
  end
  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      avs_readdata_o <= `PPC_UNMAPPED_DATA;
    end
    else if (do_read)
    begin
      avs_readdata_o <= next_readdata;
    end
  end
  // function select register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_function_select <= `PPC_RST_FUNC;
    end
    else if (wr_func)
    begin
      pin_function_select <= next_function;
    end
  end
  // drive strength register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      drive_strength_select <= `PPC_RST_HALF;
    end
    else if (wr_drive)
    begin
      drive_strength_select <= next_drive;
    end
  end
  // input path enable register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      input_path_enable <= `PPC_RST_HALF;
    end
    else if (wr_inen)
    begin
      input_path_enable <= next_inen;
    end
  end
  // output enable register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      output_drive_enable <= `PPC_RST_HALF;
    end
    else if (wr_outen)
    begin
      output_drive_enable <= next_outen;
    end
  end
  // output data, written by byte lane or cleared bit by bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_data <= `PPC_RST_HALF;
    end
    else
    begin
      out_data <= next_out;
    end
  end
  assign pad.out = out_data;
  assign pad.oe = output_drive_enable;
  assign pad.strength = drive_strength_select;
  // pad drive, low wherever the output is not enabled
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_o <= `PPC_RST_HALF;
      pin_oe_o <= `PPC_RST_HALF;
    end
    else
    begin
      pin_o <= next_pad;
      pin_oe_o <= pad.oe;
    end
  end
  // pad strength
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      drive_strength_o <= `PPC_RST_HALF;
    end
    else
    begin
      drive_strength_o <= pad.strength;
    end
  end
  // pin multiplexer select
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_function_o <= `PPC_RST_FUNC;
    end
    else
    begin
      pin_function_o <= pin_function_select;
    end
  end
endmodule

// ### include/ppc_map.svh
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// byte offsets of the port registers
`define PPC_OFF_FUNC 4'h0
`define PPC_OFF_CLR 4'h4
`define PPC_OFF_DRIVE 4'h8
`define PPC_OFF_INEN 4'hc
`define PPC_OFF_OUTEN 5'h10
`define PPC_OFF_OUT 5'h14
`define PPC_OFF_IN 5'h18
// reset values
`define PPC_RST_FUNC 32'h0000_0000
`define PPC_RST_HALF 16'h0000
`define PPC_RST_WAIT 1'b1
// zero fill for upper read lanes and idle clear mask
`define PPC_ZERO_HALF 16'h0000
// bus answer for unmapped reads
`define PPC_UNMAPPED_DATA 32'h0000_0000
`endif

// ### include/ppc_pkg.sv
package ppc_pkg;
  // avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } ppc_req_type;
  // per-pin pad controls
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] strength;
  } ppc_pad_type;
  typedef enum logic [1:0] {ppc_fn_gpio, ppc_fn_alt1, ppc_fn_alt2, ppc_fn_alt3} ppc_func_type;
endpackage

// ### rtl/ppc_pin_sync.sv
`timescale 1ns/100ps
module ppc_pin_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins and enables
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] enable_i,
  // registered input value
  output logic [WIDTH-1:0] value_o
);
  initial
  begin
    if (WIDTH < 1) $error("width must be positive");
  end
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  wire [WIDTH-1:0] masked = stage_two & enable_i;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_one <= '0;
      stage_two <= '0;
      value_o <= '0;
    end
    else
    begin
      stage_one <= pin_i;
      stage_two <= stage_one;
      value_o <= masked;
    end
  end
endmodule

// ### tb/ppc_port_chk.sv
`timescale 1ns/100ps
module ppc_port_chk (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // pads
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe_o,
  input wire logic [15:0] drive_strength_o,
  input wire logic [31:0] pin_function_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr = avs_write_i & !avs_waitrequest_o;
  wire wf = wr & avs_address_i == 5'h00;
  wire wc = wr & avs_address_i == 5'h04;
  wire wd = wr & avs_address_i == 5'h08;
  wire rc = avs_read_i & !avs_waitrequest_o & avs_address_i == 5'h04;
  wire [31:0] lane = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  // register lands on the completing edge, pad output one edge later
  property p_fn;
    wf |=> ##1 pin_function_o == (($past(pin_function_o) & ~$past(lane, 2))
      | ($past(avs_writedata_i, 2) & $past(lane, 2)));
  endproperty
  a_fn: assert property (p_fn) else $error("function write lost");
  property p_fs; !wf |=> ##1 $stable(pin_function_o); endproperty
  a_fs: assert property (p_fs) else $error("function moved");
  property p_ds;
    wd |=> ##1 drive_strength_o == (($past(drive_strength_o) & ~$past(lane[15:0], 2))
      | ($past(avs_writedata_i[15:0], 2) & $past(lane[15:0], 2)));
  endproperty
  a_ds: assert property (p_ds) else $error("strength write lost");
  property p_dh; !wd |=> ##1 $stable(drive_strength_o); endproperty
  a_dh: assert property (p_dh) else $error("strength moved");
  property p_cl;
    wc |=> ##1 pin_o == ($past(pin_o)
      & ~($past(avs_writedata_i[15:0], 2) & $past(lane[15:0], 2)));
  endproperty
  a_cl: assert property (p_cl) else $error("clear wrong");
  property p_oe; (pin_o & ~pin_oe_o) == 16'h0; endproperty
  a_oe: assert property (p_oe) else $error("undriven pin high");
  property p_rz; rc |-> avs_readdata_o == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("clear read not zero");
  property p_rs; rc |=> ##1 $stable(pin_o); endproperty
  a_rs: assert property (p_rs) else $error("clear read moved pins");
endmodule
bind ppc_port ppc_port_chk chk (.*);

// ### tb/ppc_pin_model.sv
`timescale 1ns/100ps
module ppc_pin_model (
  // port drive and outside source
  input wire logic [15:0] port_out_i,
  input wire logic [15:0] port_oe_i,
  input wire logic [15:0] ext_i,
  // wire level
  output logic [15:0] level_o
);
  assign level_o = (port_out_i & port_oe_i) | (ext_i & ~port_oe_i);
endmodule

// ### tb/test_ppc_port.sv
`timescale 1ns/100ps
module test_ppc_port;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [4:0] adr = 0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdat = 0;
  logic [3:0] be = 4'hf;
  logic [15:0] ext = 0;
  logic [31:0] rdat, fn, r1, r2;
  logic wt;
  logic [15:0] pin_i, pin_o, pin_oe_o, drv;
  logic [31:0] exq[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 32'h1f997cc9;
  ppc_port uut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .drive_strength_o(drv), .pin_function_o(fn));
  ppc_pin_model pads (.port_out_i(pin_o), .port_oe_i(pin_oe_o), .ext_i(ext), .level_o(pin_i));
  initial forever #10 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wt !== 1'b0);
    rd <= 0;
    wr <= 0;
    // one idle edge so the next call never re-raises in the same step
    @(posedge clk_i);
  endtask
  task automatic rdx(input logic [4:0] a, input logic [31:0] e);
    exq.push_back(e);
    bus(0, a, 32'h0);
  endtask
  always @(posedge clk_i)
    if (rd && wt === 1'b0)
      check(rdat, exq.pop_front());
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      test_done;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 8; a++)
      rdx(5'(a * 4), 32'h0);
    repeat (4)
    begin
      r1 = $random(seed);
      r2 = $random(seed);
      ext <= r2[31:16];
      bus(1, 5'h00, r1);
      bus(1, 5'h08, r2);
      bus(1, 5'h0c, r1);
      bus(1, 5'h14, 32'hffff);
      bus(1, 5'h10, r2);
      bus(1, 5'h04, r1 >> 16);
      bus(1, 5'h1c, 32'hffffffff);
      check(fn, r1);
      check({16'h0, drv}, {16'h0, r2[15:0]});
      check({16'h0, pin_oe_o}, {16'h0, r2[15:0]});
      check({16'h0, pin_o}, {16'h0, r2[15:0] & ~r1[31:16]});
      rdx(5'h00, r1);
      rdx(5'h04, 32'h0);
      rdx(5'h14, {16'h0, ~r1[31:16]});
      rdx(5'h18, {16'h0, r1[15:0] & ((r2[15:0] & ~r1[31:16]) | (r2[31:16] & ~r2[15:0]))});
      // byte lanes: only enabled lanes are written or cleared
      be <= 4'h2;
      bus(1, 5'h08, ~r2);
      be <= 4'h1;
      bus(1, 5'h04, 32'hffff);
      be <= 4'hf;
      rdx(5'h08, {16'h0, ~r2[15:8], r2[7:0]});
      rdx(5'h14, {16'h0, ~r1[31:24], 8'h00});
    end
    test_done;
  end
endmodule
